//--- include/opp_pkg.sv
package opp_pkg;

  // Clock and timing figures, each in its own unit
  localparam int CLK_NS     = 50;    // 20 MHz system clock
  localparam int T_SETUP_US = 2;     // Least address, data, supply and strobe setup
  localparam int T_PW_US    = 100;   // Nominal program pulse width

  // Whole cycles covering a least time
  function automatic int opp_cyc_up(input int us);
    return (us * 1000 + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam logic [11:0] SETUP_CYC = 12'(opp_cyc_up(T_SETUP_US));
  localparam logic [11:0] PW_CYC    = 12'(opp_cyc_up(T_PW_US));
  // Extra cycles so the source data answer settles inside the setup window
  localparam logic [11:0] SRC_SLACK = 12'h002;
  localparam logic [11:0] SET_WAIT  = SETUP_CYC + SRC_SLACK;

  localparam int          AW        = 18;     // 256K locations
  localparam int          DW        = 8;      // Byte wide
  localparam logic [3:0]  MAX_RETRY = 4'ha;   // Retry pulses per byte

  // Sequence steps
  typedef enum logic [4:0] {
    OPP_IDLE, OPP_PWR_VCC, OPP_P1_SET, OPP_P1_PULSE, OPP_P1_HOLD,
    OPP_V_READ, OPP_V_CMP, OPP_V_SET, OPP_V_PULSE, OPP_V_HOLD,
    OPP_LOW_VPP, OPP_LOW_VCC, OPP_F_READ, OPP_F_CMP,
    OPP_ID_MFR, OPP_ID_DEV, OPP_OFF_VPP, OPP_OFF_VCC
  } opp_state_t;

  // Everything driven toward the memory socket
  typedef struct packed {
    logic [AW-1:0] addr;             // Address lines, bit 0 is lowest_address_bit
    logic [DW-1:0] dq_out;           // Data driven while programming
    logic          dq_oe_n;          // Low while the data lines are driven
    logic          ce_n;             // Chip select
    logic          oe_n;             // Output drive enable of the memory
    logic          program_strobe_n; // Program strobe
    logic          vcc_on;           // Main supply switched on
    logic          vcc_high;         // Main supply at 6.5 V, else 5.0 V
    logic          vpp_on;           // Programming supply switched on
    logic          vpp_high;         // Programming supply at 13.0 V, else 5.0 V
    logic          id_select_hv;     // id_select_address_line at the raised level
  } opp_pins_t;

  // Result toward the user
  typedef struct packed {
    logic          busy;
    logic          done;             // One-cycle pulse at the end of any job
    logic          pass_ok;
    logic          fail;
    logic [DW-1:0] mfr_code;
    logic [DW-1:0] dev_code;
  } opp_stat_t;

  // Whole state of the sequencer
  typedef struct packed {
    opp_state_t    state;
    opp_pins_t     pins;
    opp_stat_t     stat;
    logic [AW-1:0] last;             // Last address of the job
    logic [3:0]    retry;            // Retry pulses given to the current byte
    logic          mism;             // Final read has seen a mismatch
  } opp_seq_t;

endpackage

//--- rtl/opp_prog.sv
// Contract
// [RULE_01] Program strobe pulse lasts 95 to 105 us
// [RULE_02] Start at address zero, supplies at 6.5/13.0 V
// [RULE_03] First pass: one pulse per byte, no verify
// [RULE_04] Second pass verifies, up to ten retry pulses
// [RULE_05] Byte failing after ten retries fails the part
// [RULE_06] Good byte advances address until all checked
// [RULE_07] Lower supplies to 5.0 V, reread and compare
// [RULE_08] Main supply up first, down last; the identification read switches both supplies on in the same cycle
// [RULE_09] Identification: maker code at bit 0 low, else type
// [RULE_10] Identification needs raised level on select line
// [RULE_11] Pulse with chip select on, output drive off
module opp_prog (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               start,      // Program and check addresses 0..last_addr
  input  wire logic               id_start,   // Read the two identification codes
  input  wire logic [17:0]        last_addr,  // Taken at start
  input  wire logic [7:0]         src_data,   // Source byte for pins.addr
  input  wire logic [7:0]         dq_in,      // Data lines as seen at the socket
  output opp_pkg::opp_pins_t      pins,       // Socket side
  output opp_pkg::opp_stat_t      stat        // User side
);

  opp_pkg::opp_seq_t st;          // Registered state
  opp_pkg::opp_seq_t next_st;     // Next state
  logic              tload;       // Restart the step timer
  logic [11:0]       tlen;        // Length of the next step
  logic              expired;     // Current step has run its length
  logic              same;        // Socket byte equals source byte
  logic              at_last;     // Current address is the last of the job

  assign same    = (dq_in == src_data);
  assign at_last = (st.pins.addr == st.last);

  // One timer paces every step except idle and the two compare steps; one step waits at a time
  opp_timer opp_timer_i (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (tload),
    .len     (tlen),
    .expired (expired)
  );

  // Sequencer
  always_comb begin
    next_st          = st;
    next_st.stat.done = 1'b0;
    tload            = 1'b0;
    tlen             = opp_pkg::SET_WAIT;
    case (st.state)
      opp_pkg::OPP_IDLE: begin
        if (start) begin
          next_st.pins.vcc_on   = 1'b1;              // RULE_08
          next_st.pins.vcc_high = 1'b1;              // RULE_02
          next_st.pins.addr     = '0;                // RULE_02
          next_st.last          = last_addr;
          next_st.stat.busy     = 1'b1;
          next_st.stat.pass_ok  = 1'b0;
          next_st.stat.fail     = 1'b0;
          next_st.retry         = 4'h0;
          next_st.mism          = 1'b0;
          tload                 = 1'b1;
          next_st.state         = opp_pkg::OPP_PWR_VCC;
        end else if (id_start) begin
          // Read mode at 5 V with the programming supply tied along
          next_st.pins.vcc_on       = 1'b1;
          next_st.pins.vpp_on       = 1'b1;
          next_st.pins.id_select_hv = 1'b1;          // RULE_10
          next_st.pins.addr         = '0;            // RULE_09
          next_st.pins.ce_n         = 1'b0;
          next_st.pins.oe_n         = 1'b0;
          next_st.stat.busy         = 1'b1;
          tload                     = 1'b1;
          next_st.state             = opp_pkg::OPP_ID_MFR;
        end
      end
      opp_pkg::OPP_PWR_VCC: begin
        if (expired) begin
          // Programming supply only once the main one has settled
          next_st.pins.vpp_on   = 1'b1;              // RULE_08
          next_st.pins.vpp_high = 1'b1;              // RULE_02
          next_st.pins.ce_n     = 1'b0;              // RULE_11
          next_st.pins.dq_oe_n  = 1'b0;
          tload                 = 1'b1;
          next_st.state         = opp_pkg::OPP_P1_SET;
        end
      end
      opp_pkg::OPP_P1_SET, opp_pkg::OPP_V_SET: begin
        // Data follows the source until the pulse starts
        next_st.pins.dq_out = src_data;
        if (expired) begin
          next_st.pins.program_strobe_n = 1'b0;      // RULE_11
          tload                         = 1'b1;
          tlen                          = opp_pkg::PW_CYC; // RULE_01
          next_st.state = (st.state == opp_pkg::OPP_P1_SET) ? opp_pkg::OPP_P1_PULSE
                                                            : opp_pkg::OPP_V_PULSE;
        end
      end
      opp_pkg::OPP_P1_PULSE, opp_pkg::OPP_V_PULSE: begin
        if (expired) begin
          next_st.pins.program_strobe_n = 1'b1;      // RULE_01
          tload                         = 1'b1;
          tlen                          = opp_pkg::SETUP_CYC;
          next_st.state = (st.state == opp_pkg::OPP_P1_PULSE) ? opp_pkg::OPP_P1_HOLD
                                                              : opp_pkg::OPP_V_HOLD;
        end
      end
      opp_pkg::OPP_P1_HOLD: begin
        if (expired) begin
          tload = 1'b1;
          if (at_last) begin
            // Second pass restarts at the first byte, now reading
            next_st.pins.addr    = '0;               // RULE_04
            next_st.pins.dq_oe_n = 1'b1;
            next_st.pins.oe_n    = 1'b0;             // RULE_11
            next_st.retry        = 4'h0;
            next_st.state        = opp_pkg::OPP_V_READ;
          end else begin
            // No read in this pass
            next_st.pins.addr = st.pins.addr + 18'h00001; // RULE_03
            next_st.state     = opp_pkg::OPP_P1_SET;
          end
        end
      end
      opp_pkg::OPP_V_HOLD: begin
        if (expired) begin
          next_st.pins.dq_oe_n = 1'b1;
          next_st.pins.oe_n    = 1'b0;               // RULE_11
          tload                = 1'b1;
          next_st.state        = opp_pkg::OPP_V_READ;
        end
      end
      opp_pkg::OPP_V_READ: begin
        if (expired) begin
          next_st.state = opp_pkg::OPP_V_CMP;
        end
      end
      opp_pkg::OPP_V_CMP: begin
        tload = 1'b1;
        if (same) begin
          next_st.retry = 4'h0;
          if (at_last) begin
            // Programming supply drops first
            next_st.pins.oe_n     = 1'b1;
            next_st.pins.vpp_high = 1'b0;            // RULE_07
            next_st.state         = opp_pkg::OPP_LOW_VPP;
          end else begin
            next_st.pins.addr = st.pins.addr + 18'h00001; // RULE_06
            next_st.state     = opp_pkg::OPP_V_READ;
          end
        end else if (st.retry == opp_pkg::MAX_RETRY) begin
          // Part is bad: stop and power down
          next_st.stat.fail     = 1'b1;              // RULE_05
          next_st.pins.oe_n     = 1'b1;
          next_st.pins.ce_n     = 1'b1;
          next_st.pins.vpp_on   = 1'b0;              // RULE_08
          next_st.pins.vpp_high = 1'b0;
          next_st.state         = opp_pkg::OPP_OFF_VPP;
        end else begin
          next_st.retry        = st.retry + 4'h1;    // RULE_04
          next_st.pins.oe_n    = 1'b1;
          next_st.pins.dq_oe_n = 1'b0;
          next_st.state        = opp_pkg::OPP_V_SET;
        end
      end
      opp_pkg::OPP_LOW_VPP: begin
        if (expired) begin
          next_st.pins.vcc_high = 1'b0;              // RULE_07
          tload                 = 1'b1;
          next_st.state         = opp_pkg::OPP_LOW_VCC;
        end
      end
      opp_pkg::OPP_LOW_VCC: begin
        if (expired) begin
          next_st.pins.addr = '0;                    // RULE_07
          next_st.pins.oe_n = 1'b0;
          tload             = 1'b1;
          next_st.state     = opp_pkg::OPP_F_READ;
        end
      end
      opp_pkg::OPP_F_READ: begin
        if (expired) begin
          next_st.state = opp_pkg::OPP_F_CMP;
        end
      end
      opp_pkg::OPP_F_CMP: begin
        // Every byte is read even after a mismatch, so the verdict covers all
        tload = 1'b1;
        if (at_last) begin
          next_st.stat.pass_ok = same && !st.mism;   // RULE_07
          next_st.stat.fail    = !same || st.mism;
          next_st.pins.oe_n    = 1'b1;
          next_st.pins.ce_n    = 1'b1;
          next_st.pins.vpp_on  = 1'b0;               // RULE_08
          next_st.state        = opp_pkg::OPP_OFF_VPP;
        end else begin
          next_st.mism      = st.mism || !same;
          next_st.pins.addr = st.pins.addr + 18'h00001;
          next_st.state     = opp_pkg::OPP_F_READ;
        end
      end
      opp_pkg::OPP_ID_MFR: begin
        if (expired) begin
          next_st.stat.mfr_code = dq_in;             // RULE_09
          next_st.pins.addr[0]  = 1'b1;              // RULE_09
          tload                 = 1'b1;
          next_st.state         = opp_pkg::OPP_ID_DEV;
        end
      end
      opp_pkg::OPP_ID_DEV: begin
        if (expired) begin
          next_st.stat.dev_code     = dq_in;         // RULE_09
          next_st.pins.id_select_hv = 1'b0;
          next_st.pins.oe_n         = 1'b1;
          next_st.pins.ce_n         = 1'b1;
          next_st.pins.vpp_on       = 1'b0;          // RULE_08
          tload                     = 1'b1;
          next_st.state             = opp_pkg::OPP_OFF_VPP;
        end
      end
      opp_pkg::OPP_OFF_VPP: begin
        if (expired) begin
          next_st.pins.vcc_on   = 1'b0;              // RULE_08
          next_st.pins.vcc_high = 1'b0;
          tload                 = 1'b1;
          next_st.state         = opp_pkg::OPP_OFF_VCC;
        end
      end
      opp_pkg::OPP_OFF_VCC: begin
        if (expired) begin
          next_st.stat.busy = 1'b0;
          next_st.stat.done = 1'b1;
          next_st.state     = opp_pkg::OPP_IDLE;
        end
      end
      default: begin
        next_st.state = opp_pkg::OPP_IDLE;
      end
    endcase
  end

  // Register the state; socket idles with everything released and unpowered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st                       <= '0;
      st.state                 <= opp_pkg::OPP_IDLE;
      st.pins.dq_oe_n          <= 1'b1;
      st.pins.ce_n             <= 1'b1;
      st.pins.oe_n             <= 1'b1;
      st.pins.program_strobe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign pins = st.pins;
  assign stat = st.stat;

  // Length of the current low strobe, for checking only
  logic [11:0] low_len;
  always_ff @(posedge clk) begin
    if (sys_rst || st.pins.program_strobe_n) begin
      low_len <= 12'h000;
    end else begin
      low_len <= low_len + 12'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  pulse_width_a: assert property ($rose(st.pins.program_strobe_n) |-> // RULE_01
    low_len == opp_pkg::PW_CYC) else $error("program pulse length wrong");
  prog_supply_a: assert property (!st.pins.program_strobe_n |-> // RULE_02
    st.pins.vcc_high && st.pins.vpp_high) else $error("pulse without raised supplies");
  first_pass_a: assert property (st.state inside {opp_pkg::OPP_P1_SET, // RULE_03
    opp_pkg::OPP_P1_PULSE, opp_pkg::OPP_P1_HOLD} |-> st.pins.oe_n)
    else $error("read during first pass");
  retry_limit_a: assert property (st.retry <= opp_pkg::MAX_RETRY) // RULE_04
    else $error("too many retry pulses");
  fail_stop_a: assert property (st.state == opp_pkg::OPP_V_CMP && !same && // RULE_05
    st.retry == opp_pkg::MAX_RETRY |=> st.stat.fail && st.state == opp_pkg::OPP_OFF_VPP)
    else $error("failed byte did not stop");
  advance_addr_a: assert property (st.state == opp_pkg::OPP_V_CMP && same && // RULE_06
    !at_last |=> st.pins.addr == $past(st.pins.addr) + 18'h00001)
    else $error("address did not advance");
  final_read_a: assert property (st.state == opp_pkg::OPP_F_CMP |-> // RULE_07
    st.pins.vcc_on && !st.pins.vcc_high && !st.pins.vpp_high) else $error("final read not at 5 V");
  supply_order_a: assert property (st.pins.vpp_on |-> st.pins.vcc_on) // RULE_08
    else $error("programming supply without main supply");
  id_level_a: assert property (st.state inside {opp_pkg::OPP_ID_MFR, // RULE_10
    opp_pkg::OPP_ID_DEV} |-> st.pins.id_select_hv && st.pins.addr[0] ==
    (st.state == opp_pkg::OPP_ID_DEV)) else $error("identification pins wrong");
  strobe_pins_a: assert property (!st.pins.program_strobe_n |-> !st.pins.ce_n && // RULE_11
    st.pins.oe_n && !st.pins.dq_oe_n) else $error("pulse with wrong control pins");

  pass_seen_c: cover property ($rose(st.stat.pass_ok));
  fail_seen_c: cover property (st.state == opp_pkg::OPP_V_CMP && !same &&
    st.retry == opp_pkg::MAX_RETRY);
  retry_ok_c: cover property (st.state == opp_pkg::OPP_V_CMP && same && st.retry != 4'h0);
  id_done_c: cover property (st.state == opp_pkg::OPP_ID_DEV && expired);

endmodule // opp_prog

//--- rtl/opp_timer.sv
module opp_timer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        load,
  input  wire logic [11:0] len,
  output logic             expired
);

  // Whole state of the timer
  typedef struct packed {
    logic [11:0] cnt;              // Cycles still to run
  } opp_tmr_t;

  opp_tmr_t st;                    // Registered state
  opp_tmr_t next_st;               // Next state

  // A load of len keeps the caller in its step exactly len cycles
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = len - 12'h001;
    end else if (st.cnt != 12'h000) begin
      next_st.cnt = st.cnt - 12'h001;
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = (st.cnt == 12'h000);

endmodule // opp_timer

//--- tb/opp_mem_model.sv
// Behavioural socket model: a small slice of the one-time programmable memory
module opp_mem_model #(
  parameter logic [7:0] MFR_ID = 8'h3c,  // Arbitrary maker code, not a real one
  parameter logic [7:0] DEV_ID = 8'hc3   // Arbitrary type code, not a real one
) (
  input  wire logic               clk,
  input  wire logic               wipe,        // Erase cells and clear all monitors
  input  wire opp_pkg::opp_pins_t pins,        // Everything the sequencer drives
  input  wire logic [17:0]        weak_addr,   // Cell that needs several pulses
  input  wire integer             weak_need,   // Pulses that cell needs to take data
  input  wire logic [17:0]        flaky_addr,  // Cell that misreads at 5.0 V only
  input  wire logic [3:0]         peek_addr,   // Back door read address
  output logic [7:0]              dq_in,       // Data lines seen at the socket
  output logic [7:0]              peek_data,   // Stored byte at peek_addr
  output int                      peek_pulses, // Pulses seen at peek_addr
  output int                      pulses,      // All pulses since wipe
  output logic [17:0]             first_pa,    // Address of the first pulse
  output logic                    bad_width,   // A pulse outside 95 to 105 us
  output logic                    bad_cond     // Pins or supplies wrong at some time
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [16];  // Only low addresses are modelled; jobs stay small
  int         pcnt [16]; // Pulses per cell
  int         run;       // Cycles the strobe has been low
  logic [3:0] a;         // Cell index
  int         need;      // Pulses the addressed cell needs

  assign a           = pins.addr[3:0];
  assign need        = (pins.addr == weak_addr) ? weak_need : 1;
  assign peek_data   = mem[peek_addr];
  assign peek_pulses = pcnt[peek_addr];

  // Cell programming, monitors and data line behaviour
  always @(posedge clk) begin
    if (wipe) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 8'hff;
        pcnt[i] <= 0;
      end
      pulses <= 0;
      run <= 0;
      bad_width <= 1'b0;
      bad_cond <= 1'b0;
      first_pa <= '1;
      dq_in <= 8'h00;
    end else begin
      // Programming supply never without, or above, the main supply
      if ((pins.vpp_on && !pins.vcc_on) || (pins.vpp_high && !pins.vcc_high)) begin
        bad_cond <= 1'b1;
      end
      if (!pins.program_strobe_n) begin
        run <= run + 1;
        // During a pulse: selected, outputs off, data driven, raised supplies
        if (pins.ce_n || !pins.oe_n || pins.dq_oe_n || !pins.vcc_high || !pins.vpp_high) begin
          bad_cond <= 1'b1;
        end
      end else if (run > 0) begin
        // Pulse just ended: judge its width in ns
        run <= 0;
        if (run * 50 < 95000 || run * 50 > 105000) begin
          bad_width <= 1'b1;
        end
        pulses <= pulses + 1;
        pcnt[a] <= pcnt[a] + 1;
        if (pulses == 0) begin
          first_pa <= pins.addr;
        end
        // Weak cells only take the data after enough pulses
        if (pcnt[a] + 1 >= need) begin
          mem[a] <= mem[a] & pins.dq_out;
        end
      end
      if (!pins.dq_oe_n) begin
        dq_in <= pins.dq_out;
      end else if (!pins.ce_n && !pins.oe_n && pins.id_select_hv) begin
        dq_in <= pins.addr[0] ? DEV_ID : MFR_ID;
      end else if (!pins.ce_n && !pins.oe_n) begin
        // The flaky cell reads bit 0 inverted once the supply is back at 5.0 V
        dq_in <= mem[a] ^ {7'h00, (pins.addr == flaky_addr) && !pins.vcc_high};
      end else begin
        // Released lines: a changing pattern, never the last value
        dq_in <= ~dq_in;
      end
    end
  end
endmodule // opp_mem_model

//--- tb/opp_prog_test.sv
// Self-checking bench for the programming sequencer
module opp_prog_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] MFR_X = 8'h3c; // Arbitrary maker code
  localparam logic [7:0] DEV_X = 8'hc3; // Arbitrary type code

  logic               clk, sys_rst, start, id_start, wipe;
  logic [17:0]        last_addr, weak_addr, flaky_addr, first_pa;
  logic [7:0]         src_data, dq_in, peek_data;
  logic [3:0]         peek_addr;
  logic               bad_width, bad_cond;
  int                 weak_need, peek_pulses, pulses;
  int                 bad_count, check_count;
  opp_pkg::opp_pins_t pins;
  opp_pkg::opp_stat_t stat;

  `define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end

  opp_prog opp_prog_i (.clk(clk), .sys_rst(sys_rst), .start(start), .id_start(id_start),
    .last_addr(last_addr), .src_data(src_data), .dq_in(dq_in), .pins(pins), .stat(stat));

  opp_mem_model #(.MFR_ID(MFR_X), .DEV_ID(DEV_X)) opp_mem_model_i (.clk(clk), .wipe(wipe),
    .pins(pins), .weak_addr(weak_addr), .weak_need(weak_need), .flaky_addr(flaky_addr),
    .peek_addr(peek_addr), .dq_in(dq_in), .peek_data(peek_data), .peek_pulses(peek_pulses),
    .pulses(pulses), .first_pa(first_pa), .bad_width(bad_width), .bad_cond(bad_cond));

  // Source image: a pattern with zero bits so programming is visible
  function automatic logic [7:0] src_of(input logic [17:0] addr);
    return addr[7:0] ^ 8'h5a;
  endfunction

  // Source data answers one cycle after the address moves
  always @(posedge clk) begin
    src_data <= src_of(pins.addr);
  end

  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Verdict; the only place the run ends
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Fresh socket, then one job; cyc counts edges from take to done
  task automatic do_job(input logic is_id, input logic [17:0] la, input logic [17:0] wa,
                        input int wn, input logic [17:0] fa, output int cyc);
    @(posedge clk);
    wipe <= 1'b1;
    weak_addr <= wa;
    weak_need <= wn;
    flaky_addr <= fa;
    @(posedge clk);
    wipe <= 1'b0;
    start <= !is_id;
    id_start <= is_id;
    last_addr <= la;
    @(posedge clk);
    start <= 1'b0;
    id_start <= 1'b0;
    cyc = 0;
    // Bounded wait: a stuck job ends as a mismatch, not a hang
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (stat.done !== 1'b1 && cyc < 60000);
    `CHECK(stat.done, 1'b1)
    `CHECK(stat.busy, 1'b0)
    `CHECK(pins.vcc_on, 1'b0)
    `CHECK(pins.vpp_on, 1'b0)
    `CHECK(bad_width, 1'b0)
    `CHECK(bad_cond, 1'b0)
  endtask

  // Pulse count and stored byte of one cell through the back door
  task automatic check_cell(input logic [3:0] ca, input int exp_p, input logic [7:0] exp_d);
    @(posedge clk);
    peek_addr <= ca;
    @(posedge clk);
    #1;
    `CHECK(peek_pulses, exp_p)
    `CHECK(peek_data, exp_d)
  endtask

  // Identification read: both codes, fixed length
  task automatic s_ident();
    int cyc;
    do_job(1'b1, 18'h0, 18'h3ffff, 1, 18'h3ffff, cyc);
    // Four steps of 42 cycles each, counted from the take edge
    `CHECK(cyc, 168)
    `CHECK(stat.mfr_code, MFR_X)
    `CHECK(stat.dev_code, DEV_X)
    `CHECK(pulses, 0)
  endtask

  // Three good bytes: one pulse each, pass at the end
  task automatic s_clean();
    int cyc;
    do_job(1'b0, 18'h2, 18'h3ffff, 1, 18'h3ffff, cyc);
    `CHECK(stat.pass_ok, 1'b1)
    `CHECK(stat.fail, 1'b0)
    `CHECK(first_pa, 18'h0)
    `CHECK(pulses, 3)
    for (int i = 0; i < 3; i++) begin
      check_cell(4'(i), 1, src_of(18'(i)));
    end
  endtask

  // Cell 0 takes the data on the last allowed retry; cell 1 still follows
  task automatic s_retry_edge();
    int cyc;
    do_job(1'b0, 18'h1, 18'h0, 11, 18'h3ffff, cyc);
    `CHECK(stat.pass_ok, 1'b1)
    `CHECK(stat.fail, 1'b0)
    check_cell(4'h0, 11, src_of(18'h0));
    check_cell(4'h1, 1, src_of(18'h1));
  endtask

  // Cell 0 never takes: ten retries, then the part fails
  task automatic s_exhaust();
    int cyc;
    do_job(1'b0, 18'h1, 18'h0, 12, 18'h3ffff, cyc);
    `CHECK(stat.fail, 1'b1)
    `CHECK(stat.pass_ok, 1'b0)
    `CHECK(pulses, 12)
    check_cell(4'h0, 11, 8'hff);
  endtask

  // Cell 1 verifies at raised supply but misreads at 5.0 V
  task automatic s_final_read();
    int cyc;
    do_job(1'b0, 18'h1, 18'h3ffff, 1, 18'h1, cyc);
    `CHECK(stat.fail, 1'b1)
    `CHECK(stat.pass_ok, 1'b0)
    `CHECK(pulses, 2)
  endtask

  // Main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    sys_rst = 1'b1;
    start = 1'b0;
    id_start = 1'b0;
    wipe = 1'b1;
    last_addr = '0;
    weak_addr = '1;
    flaky_addr = '1;
    weak_need = 1;
    peek_addr = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wipe <= 1'b0;
    s_ident();
    s_clean();
    s_retry_edge();
    s_exhaust();
    s_final_read();
    end_of_test();
  end

  // Watchdog: the jobs above need about 63k cycles
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule // opp_prog_test
